// *** rtl/sdio_defs.svh ***
// Functional notes
// RULE1: Four inputs, each mapped to a function bit
// RULE2: Each input's routing configured independently
// RULE3: Separate active-level setting per input
// RULE4: Inputs forceable by setting or Modbus bit
// RULE5: Three outputs, each from assignable function bit
// RULE6: Per-output active level plus forcing register
// RULE7: Valid on low, high, rise, fall, both
// RULE8: Inputs one and two need >3 ms stability
// RULE9: Inputs three and four need >0.25 ms
// RULE10: Outputs one and two may carry encoder
// RULE11: Function selector accepts codes 0 to 99
// RULE12: Pins synchronised, filter counted in clocks
`ifndef SDIO_DEFS_SVH
`define SDIO_DEFS_SVH

// Sizes
`define SDIO_NUM_IN        4
`define SDIO_NUM_OUT       3
`define SDIO_NUM_LS        2
`define SDIO_NUM_FUNC      100
`define SDIO_SEL_W         7
`define SDIO_ACT_W         3
`define SDIO_FUNC_MAX      7'h63
`define SDIO_FUNC_NONE     7'h00

// Timing
`define SDIO_CLK_KHZ       25000
`define SDIO_LS_TIME_US    3000
`define SDIO_HS_TIME_US    250
`define SDIO_US_PER_MS     1000

// Register byte offsets
`define SDIO_ADDR_W        8
`define SDIO_OFS_IN_SEL0   8'h00
`define SDIO_OFS_IN_SEL1   8'h04
`define SDIO_OFS_IN_SEL2   8'h08
`define SDIO_OFS_IN_SEL3   8'h0c
`define SDIO_OFS_IN_ACT    8'h10
`define SDIO_OFS_IN_FRC    8'h14
`define SDIO_OFS_MB_FRC    8'h18
`define SDIO_OFS_OUT_SEL0  8'h1c
`define SDIO_OFS_OUT_SEL1  8'h20
`define SDIO_OFS_OUT_SEL2  8'h24
`define SDIO_OFS_OUT_CTL   8'h28
`define SDIO_OFS_ENC_SEL   8'h2c
`define SDIO_OFS_STATUS    8'h30

// Field positions
`define SDIO_FRC_EN_LSB    0
`define SDIO_FRC_LVL_LSB   4
`define SDIO_OCTL_HI_LSB   0
`define SDIO_OCTL_FEN_LSB  4
`define SDIO_OCTL_FVAL_LSB 8
`define SDIO_ST_LVL_LSB    0
`define SDIO_ST_VLD_LSB    4
`define SDIO_ST_DO_LSB     8

// Reset values
`define SDIO_RST_SEL0      7'h01
`define SDIO_RST_SEL1      7'h2a
`define SDIO_RST_SEL2      7'h00
`define SDIO_RST_SEL3      7'h00
`define SDIO_RST_ACT       3'h1
`define SDIO_RST_OUT_HI    3'h7

`endif

// *** rtl/sdio_pkg.sv ***
package sdio_pkg;
    // Condition under which an input's function becomes valid
    typedef enum logic [2:0] {
        SDIO_ACT_LOW  = 3'h0,
        SDIO_ACT_HIGH = 3'h1,
        SDIO_ACT_RISE = 3'h2,
        SDIO_ACT_FALL = 3'h3,
        SDIO_ACT_BOTH = 3'h4
    } sdio_act_e;

    // Encoder routing onto the first two outputs
    typedef enum logic [1:0] {
        SDIO_ENC_OFF = 2'h0,
        SDIO_ENC_AB  = 2'h1,
        SDIO_ENC_ZB  = 2'h2
    } sdio_enc_e;
endpackage

// *** rtl/sdio_filter.sv ***
`timescale 1ns/1ps
module sdio_filter #(
    parameter int unsigned STABLE_CYCLES = 75001
) (
    input  wire logic pclk,    // Drive clock
    input  wire logic presetn, // Async reset, active low
    input  wire logic sample,  // Synchronised pin level
    output logic      level    // Accepted level
);
    localparam int unsigned CW = $clog2(STABLE_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(STABLE_CYCLES - 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          level;
    } sdio_flt_s;

    sdio_flt_s flt_reg;
    sdio_flt_s flt_next;

    // Counting in clocks keeps the window exact at any rate
    if (STABLE_CYCLES < 1) begin : g_chk
        $error("sdio_filter needs at least one stable cycle");
    end

    // New level must persist for the whole window; any glitch restarts it
    always_comb begin
        flt_next = flt_reg;
        if (sample == flt_reg.level) begin
            flt_next.cnt = '0;
        end else if (flt_reg.cnt == LAST) begin // see RULE12
            flt_next.level = sample;
            flt_next.cnt   = '0;
        end else begin
            flt_next.cnt = flt_reg.cnt + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flt_reg <= '0;
        end else begin
            flt_reg <= flt_next;
        end
    end

    assign level = flt_reg.level;
endmodule // sdio_filter

// *** rtl/sdio_mapper.sv ***
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps
`include "sdio_defs.svh"
module sdio_mapper #(
    parameter int unsigned LS_STABLE_CYCLES =
        `SDIO_LS_TIME_US * `SDIO_CLK_KHZ / `SDIO_US_PER_MS + 1,
    parameter int unsigned HS_STABLE_CYCLES =
        `SDIO_HS_TIME_US * `SDIO_CLK_KHZ / `SDIO_US_PER_MS + 1
) (
    input  wire logic                       pclk,                // Drive clock
    input  wire logic                       presetn,             // Async reset, active low
    input  wire logic                       psel,                // APB select
    input  wire logic                       penable,             // APB access phase
    input  wire logic                       pwrite,              // APB direction
    input  wire logic [`SDIO_ADDR_W-1:0]    paddr,               // APB byte address
    input  wire logic [31:0]                pwdata,              // APB write data
    output logic      [31:0]                prdata,              // APB read data
    output logic                            pready,              // APB ready
    output logic                            pslverr,             // APB error
    input  wire logic [`SDIO_NUM_IN-1:0]    di_pin,              // Physical inputs
    input  wire logic [`SDIO_NUM_FUNC-1:0]  output_function_bit, // Drive output functions
    input  wire logic                       enc_a,               // Encoder A
    input  wire logic                       enc_b,               // Encoder B
    input  wire logic                       enc_z,               // Encoder Z
    output logic      [`SDIO_NUM_FUNC-1:0]  input_function_bit,  // Input functions to drive
    output logic      [`SDIO_NUM_OUT-1:0]   do_pin               // Physical outputs
);
    localparam int NI = `SDIO_NUM_IN;
    localparam int NO = `SDIO_NUM_OUT;
    localparam int SW = `SDIO_SEL_W;
    localparam int AW = `SDIO_ACT_W;

    typedef struct packed {
        logic [NI-1:0]          sync1;
        logic [NI-1:0]          sync2;
        logic [NI-1:0]          prev;
        logic [NI-1:0][SW-1:0]  in_sel;
        logic [NI-1:0][AW-1:0]  in_act;
        logic [NI-1:0]          frc_en;
        logic [NI-1:0]          frc_lvl;
        logic [NI-1:0]          mb_en;
        logic [NI-1:0]          mb_lvl;
        logic [NI-1:0]          valid;
        logic [NO-1:0][SW-1:0]  out_sel;
        logic [NO-1:0]          out_hi;
        logic [NO-1:0]          ofrc_en;
        logic [NO-1:0]          ofrc_val;
        logic [1:0]             enc_sel;
        logic [`SDIO_NUM_FUNC-1:0] in_func;
        logic [NO-1:0]          dout;
        logic [31:0]            prdata;
        logic                   pready;
        logic                   pslverr;
    } sdio_state_s;

    sdio_state_s st_reg;
    sdio_state_s st_next;
    logic [NI-1:0] filt;

    // Selector width must cover every function code
    if ((1 << SW) < `SDIO_NUM_FUNC || LS_STABLE_CYCLES < 1 || HS_STABLE_CYCLES < 1)
    begin : g_chk
        $error("sdio_mapper parameters out of range");
    end

    // Low-speed inputs get the long window, high-speed the short one
    for (genvar i = 0; i < NI; i++) begin : g_filt
        sdio_filter #(
            .STABLE_CYCLES ((i < `SDIO_NUM_LS) ? LS_STABLE_CYCLES : HS_STABLE_CYCLES)
        ) u_filt (                          // see RULE8 see RULE9
            .pclk    (pclk),
            .presetn (presetn),
            .sample  (st_reg.sync2[i]),
            .level   (filt[i])
        );
    end

    // Status word seen by software
    function automatic logic [31:0] status_word(input sdio_state_s s);
        logic [31:0] w;
        w = '0;
        w[`SDIO_ST_LVL_LSB +: NI] = s.prev;
        w[`SDIO_ST_VLD_LSB +: NI] = s.valid;
        w[`SDIO_ST_DO_LSB +: NO]  = s.dout;
        return w;
    endfunction

    // Read mux; reserved bits read as zero
    function automatic logic [31:0] read_word(input sdio_state_s s,
                                              input logic [`SDIO_ADDR_W-1:0] a);
        logic [31:0] w;
        w = '0;
        unique case (a)
            `SDIO_OFS_IN_SEL0:  w[SW-1:0] = s.in_sel[0];
            `SDIO_OFS_IN_SEL1:  w[SW-1:0] = s.in_sel[1];
            `SDIO_OFS_IN_SEL2:  w[SW-1:0] = s.in_sel[2];
            `SDIO_OFS_IN_SEL3:  w[SW-1:0] = s.in_sel[3];
            `SDIO_OFS_IN_ACT:   w[NI*AW-1:0] = s.in_act;
            `SDIO_OFS_IN_FRC: begin
                w[`SDIO_FRC_EN_LSB +: NI]  = s.frc_en;
                w[`SDIO_FRC_LVL_LSB +: NI] = s.frc_lvl;
            end
            `SDIO_OFS_MB_FRC: begin
                w[`SDIO_FRC_EN_LSB +: NI]  = s.mb_en;
                w[`SDIO_FRC_LVL_LSB +: NI] = s.mb_lvl;
            end
            `SDIO_OFS_OUT_SEL0: w[SW-1:0] = s.out_sel[0];
            `SDIO_OFS_OUT_SEL1: w[SW-1:0] = s.out_sel[1];
            `SDIO_OFS_OUT_SEL2: w[SW-1:0] = s.out_sel[2];
            `SDIO_OFS_OUT_CTL: begin
                w[`SDIO_OCTL_HI_LSB +: NO]   = s.out_hi;
                w[`SDIO_OCTL_FEN_LSB +: NO]  = s.ofrc_en;
                w[`SDIO_OCTL_FVAL_LSB +: NO] = s.ofrc_val;
            end
            `SDIO_OFS_ENC_SEL:  w[1:0] = s.enc_sel;
            `SDIO_OFS_STATUS:   w = status_word(s);
            default:            w = '0;
        endcase
        return w;
    endfunction

    // Address decode of the mapped offsets
    function automatic logic mapped(input logic [`SDIO_ADDR_W-1:0] a);
        return a inside {`SDIO_OFS_IN_SEL0, `SDIO_OFS_IN_SEL1, `SDIO_OFS_IN_SEL2,
                         `SDIO_OFS_IN_SEL3, `SDIO_OFS_IN_ACT, `SDIO_OFS_IN_FRC,
                         `SDIO_OFS_MB_FRC, `SDIO_OFS_OUT_SEL0, `SDIO_OFS_OUT_SEL1,
                         `SDIO_OFS_OUT_SEL2, `SDIO_OFS_OUT_CTL, `SDIO_OFS_ENC_SEL,
                         `SDIO_OFS_STATUS};
    endfunction

    // Selector offsets, whose data must be a legal function code
    function automatic logic is_sel(input logic [`SDIO_ADDR_W-1:0] a);
        return a inside {`SDIO_OFS_IN_SEL0, `SDIO_OFS_IN_SEL1, `SDIO_OFS_IN_SEL2,
                         `SDIO_OFS_IN_SEL3, `SDIO_OFS_OUT_SEL0, `SDIO_OFS_OUT_SEL1,
                         `SDIO_OFS_OUT_SEL2};
    endfunction

    // Whole next state
    always_comb begin
        logic [NI-1:0] lvl;
        logic [NI-1:0] vld;
        logic          fn;
        logic          wr_ok;
        lvl     = '0;
        vld     = '0;
        fn      = 1'b0;
        wr_ok   = 1'b0;
        st_next = st_reg;

        // Two-flop synchroniser in front of the filters
        st_next.sync1 = di_pin;        // see RULE12
        st_next.sync2 = st_reg.sync1;

        // Modbus force wins over the setting, both over the pin
        for (int i = 0; i < NI; i++) begin
            if (st_reg.mb_en[i]) begin
                lvl[i] = st_reg.mb_lvl[i];  // see RULE4
            end else if (st_reg.frc_en[i]) begin
                lvl[i] = st_reg.frc_lvl[i]; // see RULE4
            end else begin
                lvl[i] = filt[i];
            end
        end
        st_next.prev = lvl;

        // Edge modes give a one-cycle pulse, level modes follow the level
        for (int i = 0; i < NI; i++) begin
            unique case (st_reg.in_act[i])
                sdio_pkg::SDIO_ACT_LOW:  vld[i] = ~lvl[i];                   // see RULE7
                sdio_pkg::SDIO_ACT_HIGH: vld[i] = lvl[i];                    // see RULE7
                sdio_pkg::SDIO_ACT_RISE: vld[i] = lvl[i] & ~st_reg.prev[i];  // see RULE7
                sdio_pkg::SDIO_ACT_FALL: vld[i] = ~lvl[i] & st_reg.prev[i];  // see RULE7
                sdio_pkg::SDIO_ACT_BOTH: vld[i] = lvl[i] ^ st_reg.prev[i];   // see RULE7 see RULE3
                default:                 vld[i] = 1'b0;
            endcase
        end
        st_next.valid = vld;

        // Route each input to its own function bit; code zero is unassigned
        st_next.in_func = '0;
        for (int i = 0; i < NI; i++) begin
            if (st_reg.in_sel[i] != `SDIO_FUNC_NONE && vld[i]) begin
                st_next.in_func[st_reg.in_sel[i]] = 1'b1; // see RULE1 see RULE2
            end
        end

        // Outputs: force first, then encoder, then mapped function
        for (int j = 0; j < NO; j++) begin
            fn = output_function_bit[st_reg.out_sel[j]] ~^ st_reg.out_hi[j]; // see RULE5 see RULE6
            if (st_reg.ofrc_en[j]) begin
                st_next.dout[j] = st_reg.ofrc_val[j];    // see RULE6
            end else begin
                st_next.dout[j] = fn;
            end
        end
        if (!st_reg.ofrc_en[0]) begin
            if (st_reg.enc_sel == sdio_pkg::SDIO_ENC_AB) begin
                st_next.dout[0] = enc_a;                 // see RULE10
            end else if (st_reg.enc_sel == sdio_pkg::SDIO_ENC_ZB) begin
                st_next.dout[0] = enc_z;                 // see RULE10
            end
        end
        if (!st_reg.ofrc_en[1] && st_reg.enc_sel != sdio_pkg::SDIO_ENC_OFF) begin
            st_next.dout[1] = enc_b;                     // see RULE10
        end

        // APB setup: prepare answer so pready and data are registered
        st_next.pready  = 1'b0;
        st_next.pslverr = 1'b0;
        if (psel && !penable) begin
            st_next.pready  = 1'b1;
            st_next.prdata  = pwrite ? 32'h0 : read_word(st_reg, paddr);
            st_next.pslverr = !mapped(paddr) ||
                              (pwrite && is_sel(paddr) && pwdata[SW-1:0] > `SDIO_FUNC_MAX);
        end

        // APB access: a write lands only on the completing edge
        wr_ok = psel && penable && st_reg.pready && pwrite && !st_reg.pslverr;
        if (wr_ok) begin
            unique case (paddr)
                `SDIO_OFS_IN_SEL0:  st_next.in_sel[0] = pwdata[SW-1:0]; // see RULE11
                `SDIO_OFS_IN_SEL1:  st_next.in_sel[1] = pwdata[SW-1:0]; // see RULE11
                `SDIO_OFS_IN_SEL2:  st_next.in_sel[2] = pwdata[SW-1:0]; // see RULE11
                `SDIO_OFS_IN_SEL3:  st_next.in_sel[3] = pwdata[SW-1:0]; // see RULE11
                `SDIO_OFS_IN_ACT:   st_next.in_act = pwdata[NI*AW-1:0]; // see RULE3
                `SDIO_OFS_IN_FRC: begin
                    st_next.frc_en  = pwdata[`SDIO_FRC_EN_LSB +: NI];
                    st_next.frc_lvl = pwdata[`SDIO_FRC_LVL_LSB +: NI];
                end
                `SDIO_OFS_MB_FRC: begin
                    st_next.mb_en  = pwdata[`SDIO_FRC_EN_LSB +: NI];
                    st_next.mb_lvl = pwdata[`SDIO_FRC_LVL_LSB +: NI];
                end
                `SDIO_OFS_OUT_SEL0: st_next.out_sel[0] = pwdata[SW-1:0];
                `SDIO_OFS_OUT_SEL1: st_next.out_sel[1] = pwdata[SW-1:0];
                `SDIO_OFS_OUT_SEL2: st_next.out_sel[2] = pwdata[SW-1:0];
                `SDIO_OFS_OUT_CTL: begin
                    st_next.out_hi   = pwdata[`SDIO_OCTL_HI_LSB +: NO];
                    st_next.ofrc_en  = pwdata[`SDIO_OCTL_FEN_LSB +: NO];
                    st_next.ofrc_val = pwdata[`SDIO_OCTL_FVAL_LSB +: NO];
                end
                `SDIO_OFS_ENC_SEL:  st_next.enc_sel = pwdata[1:0];
                default: begin
                    // Status is read-only; writes are dropped
                end
            endcase
        end
    end

    // Reset leaves every input on its default function, outputs inactive
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg           <= '0;
            st_reg.in_sel[0] <= `SDIO_RST_SEL0;
            st_reg.in_sel[1] <= `SDIO_RST_SEL1;
            st_reg.in_sel[2] <= `SDIO_RST_SEL2;
            st_reg.in_sel[3] <= `SDIO_RST_SEL3;
            st_reg.in_act    <= {NI{`SDIO_RST_ACT}};
            st_reg.out_hi    <= `SDIO_RST_OUT_HI;
        end else begin
            st_reg <= st_next;
        end
    end

    // All outputs straight from state flops
    assign prdata             = st_reg.prdata;
    assign pready             = st_reg.pready;
    assign pslverr            = st_reg.pslverr;
    assign input_function_bit = st_reg.in_func;
    assign do_pin             = st_reg.dout;
endmodule // sdio_mapper

// *** verification/sdio_mapper_checker.sv ***
`timescale 1ns/1ps
// Port watcher; a shadow of output control judges forcing
module sdio_chk (
    input wire logic        pclk, // Clock
    input wire logic        presetn, // Reset
    input wire logic        psel, // Select
    input wire logic        penable, // Access
    input wire logic        pwrite, // Write
    input wire logic [7:0]  paddr, // Address
    input wire logic [31:0] pwdata, // Wdata
    input wire logic [31:0] prdata, // Rdata
    input wire logic        pready, // Ready
    input wire logic        pslverr, // Error
    input wire logic [3:0]  di_pin, // Pins in
    input wire logic [99:0] output_function_bit, // Out fn
    input wire logic        enc_a, // Enc A
    input wire logic        enc_b, // Enc B
    input wire logic        enc_z, // Enc Z
    input wire logic [99:0] input_function_bit, // In fn
    input wire logic [2:0]  do_pin // Pins out
);
    logic [10:0] ctl_q;
    wire         setup = psel && !penable;
    wire         wdone = psel && penable && pready && pwrite;

    // Shadow takes a write at the same edge the slave does
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) ctl_q <= 11'h007;
        else if (wdone && paddr == 8'h28) ctl_q <= pwdata[10:0];
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_ready; setup |=> pready; endproperty
    a_ready: assert property (p_ready) else $error("no ready");
    property p_once; pready |=> !pready; endproperty
    a_once: assert property (p_once) else $error("ready held");
    property p_bad; setup && pwrite && paddr == 8'h0c && pwdata[6:0] > 7'h63 |=> pslverr;
    endproperty
    a_bad: assert property (p_bad) else $error("code kept");
    property p_good; setup && pwrite && paddr == 8'h00 && pwdata[6:0] <= 7'h63 |=> !pslverr;
    endproperty
    a_good: assert property (p_good) else $error("code refused");
    property p_unmap; setup && paddr > 8'h30 |=> pslverr && prdata == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped");
    property p_wzero; setup && pwrite |=> prdata == 32'h0; endproperty
    a_wzero: assert property (p_wzero) else $error("write data");
    property p_none; input_function_bit[0] == 1'h0; endproperty
    a_none: assert property (p_none) else $error("code zero");
    // Forced outputs follow the force value one edge after it settles
    property p_force; $stable(ctl_q) |-> (ctl_q[6:4] & (do_pin ^ ctl_q[10:8])) == 3'h0;
    endproperty
    a_force: assert property (p_force) else $error("force");

    c_wr: cover property (wdone);
    c_err: cover property (pslverr);
    c_frc: cover property (ctl_q[4] && do_pin[0]);
endmodule // sdio_chk

bind sdio_mapper sdio_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .di_pin, .output_function_bit, .enc_a, .enc_b,
    .enc_z, .input_function_bit, .do_pin);

// *** verification/sdio_field.sv ***
`timescale 1ns/1ps
module sdio_field (
    input  wire logic       pclk, // Clock
    input  wire logic [3:0] want, // Commanded levels
    input  wire logic       bounce, // Contact chatter
    output logic      [3:0] di_pin // To the pins
);
    logic [3:0] chat = 4'h0;

    // Chatter flips each cycle, so it is never stable long enough
    always @(posedge pclk) chat <= bounce ? ~chat : 4'h0;
    // Commanded level held as long as the bench asks
    assign di_pin = want ^ chat;
endmodule // sdio_field

// *** verification/servo_digital_io_mapper_bench.sv ***
`timescale 1ns/1ps
module servo_digital_io_mapper_bench;
    localparam int LS = 8; // Short filters keep the run brief
    localparam int HS = 4;
    localparam logic [31:0] RST [12] = '{32'h1, 32'h2a, 32'h0, 32'h0, 32'h249, 32'h0,
        32'h0, 32'h0, 32'h0, 32'h0, 32'h7, 32'h0};
    logic        pclk = 1'h0;
    logic        presetn = 1'h0;
    logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0, bounce = 1'h0;
    logic        enc_a = 1'h0, enc_b = 1'h0, enc_z = 1'h0;
    logic        pready, pslverr, err, lvl, prev, rose;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [31:0] seed = 32'h000168c7;
    logic [3:0]  want = 4'h0, di_pin;
    logic [99:0] output_function_bit = '0, input_function_bit;
    logic [2:0]  do_pin;
    logic [6:0]  osel [3];
    logic [10:0] ctl;
    logic [1:0]  encs;
    int          fail_count = 0, check_count = 0, n, st;

    sdio_mapper #(.LS_STABLE_CYCLES(LS), .HS_STABLE_CYCLES(HS)) DUT (.pclk, .presetn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .di_pin,
        .output_function_bit, .enc_a, .enc_b, .enc_z, .input_function_bit, .do_pin);
    sdio_field u_field (.pclk, .want, .bounce, .di_pin);

    // 25 MHz drive clock
    always #20 pclk = ~pclk;

    function automatic logic [31:0] rnd();
        seed = {seed[30:0], 1'h0} ^ (seed[31] ? 32'h04c11db7 : 32'h0);
        return seed;
    endfunction

    // {pulse seen, final level} after the input moves to l
    function automatic logic [1:0] exp_in(logic [2:0] m, logic l);
        logic f;
        logic p;
        f = (m == sdio_pkg::SDIO_ACT_HIGH) ? l : (m == sdio_pkg::SDIO_ACT_LOW) ? !l : 1'h0;
        p = (m == sdio_pkg::SDIO_ACT_RISE) ? l : (m == sdio_pkg::SDIO_ACT_FALL) ? !l :
            (m == sdio_pkg::SDIO_ACT_BOTH) ? 1'h1 : f;
        return {p, f};
    endfunction

    // Force beats encoder, encoder beats the function bit
    function automatic logic exp_do(int k);
        logic v;
        v = output_function_bit[osel[k]] ^ !ctl[k];
        if (k == 0 && encs == 2'h1) v = enc_a;
        if (k == 0 && encs == 2'h2) v = enc_z;
        if (k == 1 && encs != 2'h0) v = enc_b;
        if (ctl[4 + k]) v = ctl[8 + k];
        return v;
    endfunction

    task automatic chk(input logic [32:0] g, input logic [32:0] e);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // One transfer; request held until ready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        n = 0;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (n >= 16) begin
            fail_count++;
            $display("ERROR %0t: no ready", $time);
            report_and_stop();
        end
        @(posedge pclk);
    endtask

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        // Reset values, refused codes, unmapped and read-only places
        for (int k = 0; k < 12; k++) begin
            apb(1'h0, 8'(4 * k), 32'h0);
            chk({err, rd}, {1'h0, RST[k]});
        end
        apb(1'h0, 8'h34, 32'h0);
        chk({err, rd}, {1'h1, 32'h0});
        apb(1'h1, 8'h30, 32'h7ff);
        chk(err, 1'h0);
        apb(1'h1, 8'h0c, 32'h64);
        chk(err, 1'h1);
        apb(1'h1, 8'h0c, 32'h63);
        apb(1'h0, 8'h0c, 32'h0);
        chk({err, rd}, {1'h0, 32'h63});
        $display("Test 0 done");
        // Every condition on input one, driven through the force path
        apb(1'h1, 8'h00, 32'h9);
        for (int m = 0; m < 5; m++) begin
            apb(1'h1, 8'h10, 32'(m));
            apb(1'h1, 8'h14, 32'h1);
            repeat (4) @(posedge pclk);
            for (int l = 1; l >= 0; l--) begin
                lvl = 1'(l);
                prev = input_function_bit[9];
                rose = 1'h0;
                apb(1'h1, 8'h14, {27'h0, lvl, 4'h1});
                repeat (8) begin
                    @(posedge pclk);
                    rose |= input_function_bit[9] & !prev;
                    prev = input_function_bit[9];
                end
                chk({rose, input_function_bit[9]}, exp_in(3'(m), lvl));
            end
        end
        // Modbus force beats the setting force
        apb(1'h1, 8'h10, 32'h249);
        apb(1'h1, 8'h14, 32'h11);
        apb(1'h1, 8'h18, 32'h01);
        repeat (4) @(posedge pclk);
        chk(input_function_bit[9], 1'h0);
        apb(1'h1, 8'h18, 32'h0);
        repeat (4) @(posedge pclk);
        chk(input_function_bit[9], 1'h1);
        apb(1'h1, 8'h14, 32'h0);
        $display("Test 1 done");
        // Pin filters: chatter refused, a held level passes after its time
        for (int k = 0; k < 4; k++) apb(1'h1, 8'(4 * k), 32'(20 + k));
        bounce <= 1'h1;
        repeat (30) begin
            @(posedge pclk);
            chk(input_function_bit[23:20], 4'h0);
        end
        bounce <= 1'h0;
        repeat (4) @(posedge pclk);
        for (int k = 0; k < 4; k++) begin
            st = (k < 2) ? LS : HS;
            n = 0;
            want[k] <= 1'h1;
            do begin
                @(posedge pclk);
                n++;
            end while (input_function_bit[20 + k] !== 1'h1 && n < 40);
            chk(n > st && n <= st + 8, 1'h1);
            if (n >= 40) report_and_stop();
            want[k] <= 1'h0;
            repeat (st + 8) @(posedge pclk);
        end
        $display("Test 2 done");
        // Output routing, level, encoder choice and forcing, random mixes
        for (int t = 0; t < 16; t++) begin
            for (int k = 0; k < 3; k++) begin
                osel[k] = 7'(rnd() % 100);
                apb(1'h1, 8'(8'h1c + 4 * k), {25'h0, osel[k]});
            end
            ctl = 11'(rnd());
            encs = 2'(t);
            if (encs != 2'h0) ctl[2:0] = 3'h7;
            apb(1'h1, 8'h28, {21'h0, ctl});
            apb(1'h1, 8'h2c, {30'h0, encs});
            output_function_bit <= 100'({rnd(), rnd(), rnd(), rnd()});
            {enc_a, enc_b, enc_z} <= 3'(rnd());
            repeat (3) @(posedge pclk);
            for (int k = 0; k < 3; k++) chk(do_pin[k], exp_do(k));
            // Status mirrors outputs; idle inputs leave level and valid clear
            apb(1'h0, 8'h30, 32'h0);
            chk(rd, {21'h0, exp_do(2), exp_do(1), exp_do(0), 8'h00});
        end
        $display("Test 3 done");
        report_and_stop();
    end
endmodule // servo_digital_io_mapper_bench
